// ### pcibp_pkg.sv
// shared constants and types for the pci build-parameter register bank
package pcibp_pkg;

    // ****************************************
    // configuration space offsets
    // ****************************************
    localparam logic [7:0] OFS_IDENT   = 8'h00;
    localparam logic [7:0] OFS_CMDSTAT = 8'h04;
    localparam logic [7:0] OFS_CLASS   = 8'h08;
    localparam logic [7:0] OFS_BAR0    = 8'h10;
    localparam logic [7:0] OFS_BAR1    = 8'h14;
    localparam logic [7:0] OFS_BAR2    = 8'h18;
    localparam logic [7:0] OFS_BOARD   = 8'h2c;
    localparam logic [7:0] OFS_CAPPTR  = 8'h34;
    localparam logic [7:0] OFS_DMA_PCI = 8'h40;
    localparam logic [7:0] OFS_DMA_RAM = 8'h44;
    localparam logic [7:0] OFS_DMA_CTL = 8'h48;
    localparam logic [7:0] OFS_HOTSWAP = 8'h80;

    // ****************************************
    // bus address map: bits 11:8 pick the space
    // ****************************************
    localparam logic [3:0] SPACE_CFG = 4'h0;
    localparam logic [3:0] SPACE_IO  = 4'h1;
    localparam int         AXI_AW    = 12;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLV  = 2'b10;

    // ****************************************
    // build variants
    // ****************************************
    localparam int VAR_TARGET  = 0;
    localparam int VAR_TDMA    = 1;
    localparam int VAR_MASTER  = 2;
    localparam int VAR_TMASTER = 3;

    // ****************************************
    // field positions and masks
    // ****************************************
    localparam int          STAT_FAST_BIT    = 21;
    localparam int          STAT_CAPLIST_BIT = 20;
    localparam int          CMD_IO_EN_BIT    = 0;
    localparam logic [15:0] CMD_WMASK        = 16'h0147;
    localparam logic [15:0] CMD_RESET        = 16'h0000;
    localparam logic [7:0]  CAP_PTR_HOTSWAP  = 8'h80;
    localparam logic [7:0]  CAP_ID_HOTSWAP   = 8'h06;
    localparam logic [7:0]  CAP_NEXT_NONE    = 8'h00;
    localparam logic [31:0] HS_WMASK         = 32'h0000_ca00;
    localparam logic [31:0] HS_RESET         = 32'h0000_0000;
    localparam logic [31:0] ADDR_WMASK       = 32'hffff_fffc;
    localparam logic [31:0] DMA_CTL_WMASK    = 32'heffc_3ffb;
    localparam logic [31:0] DMA_RESET        = 32'h0000_0000;
    localparam int          CTL_DONE_BIT     = 2;
    localparam int          CTL_REQ_BIT      = 4;
    localparam int          CTL_WIDE_BIT     = 10;
    localparam int          CTL_LEN_LSB      = 16;
    localparam int          CTL_LEN_MSB      = 27;
    localparam logic [11:0] DWORD_BYTES      = 12'h004;
    localparam logic [31:0] BAR_IO_TYPE      = 32'h0000_0001;
    localparam logic [31:0] BAR_PREFETCH     = 32'h0000_0008;
    localparam int          IO_WIN_LOG2      = 8;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [31:0] pci_addr;
        logic [31:0] ram_addr;
        logic [31:0] ctrl;
    } pcibp_dma_t;

    typedef struct packed {
        logic       beat;     // one data phase moved
        logic       finish;   // transfer complete
        logic       abort;    // transfer ended by error
        logic [1:0] err_code; // error kind with abort
    } pcibp_dma_evt_t;

endpackage

// ### pcibp_bar.sv
// one base address register with build-time size, type and prefetch bit
`timescale 1ns/1ns
`default_nettype none
module pcibp_bar
    import pcibp_pkg::*;
#(
    parameter bit PRESENT   = 1'b1,
    parameter bit IS_IO     = 1'b0,
    parameter bit PREFETCH  = 1'b0,
    parameter int SIZE_LOG2 = 8
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write port
    input  wire logic        we,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // current value
    output var  logic [31:0] value
);

    // ****************************************
    // fixed low bits and writable base bits
    // ****************************************
    localparam logic [31:0] TYPE_BITS = IS_IO ? BAR_IO_TYPE :
                                        (PREFETCH ? BAR_PREFETCH : 32'h0000_0000);
    localparam logic [31:0] WMASK = ~((32'h0000_0001 << SIZE_LOG2) - 32'h0000_0001);

    logic [31:0] merged;

    // byte lanes merge into the stored base
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            merged[i*8 +: 8] = wstrb[i] ? wdata[i*8 +: 8] : value[i*8 +: 8];
        end
    end

    // absent window reads zero and ignores writes
    always_ff @(posedge aclk) begin
        if (!aresetn || !PRESENT) begin
            value <= PRESENT ? TYPE_BITS : 32'h0000_0000;
        end else if (we) begin
            value <= (merged & WMASK) | TYPE_BITS;
        end
    end

endmodule
`default_nettype wire

// ### pcibp_regs.sv
// pci configuration header, windows and dma registers fixed by build parameters
//
// Behaviour
// - identity and class values are read-only constants
// - width parameter selects 32- or 64-bit operation
// - speed parameter drives status bit 5
// - counting parameter lets dma registers advance
// - mapping zero puts dma registers in config
// - mapping one puts them in io window
// - window0 size is two to the power
// - master-only build drops window0; its size goes unused
// - window1 enable adds register at 14h
// - window1 type selects memory or io
// - window1 size with per-type legal range
// - prefetch parameter sets memory window bit 3
// - hot-swap sets status bit, pointer, capability
// - mapping applies only to target-plus-dma build
// - master-only ignores window1 and hot-swap
// - without counting, start addresses stay put
// - capability id 06h, next pointer zero
`timescale 1ns/1ns
`default_nettype none
module pcibp_regs
    import pcibp_pkg::*;
#(
    parameter logic [15:0] part_ident_const        = 16'h0001, // arbitrary value
    parameter logic [15:0] maker_ident_const       = 16'h0002, // arbitrary value
    parameter logic [7:0]  revision_ident_const    = 8'h01,    // arbitrary value
    parameter logic [7:0]  base_class_const        = 8'h11,
    parameter logic [7:0]  sub_class_const         = 8'h80,
    parameter logic [7:0]  prog_if_const           = 8'h00,
    parameter logic [15:0] board_ident_const       = 16'h0003, // arbitrary value
    parameter logic [15:0] board_maker_ident_const = 16'h0004, // arbitrary value
    parameter int          variant                 = VAR_TDMA,
    parameter bit          wide_bus                = 1'b0,
    parameter bit          fast_clock_capable      = 1'b0,
    parameter bit          transfer_count_update_en = 1'b1,
    parameter bit          dma_regs_in_io          = 1'b0,
    parameter int          window0_size_log2       = 24,
    parameter bit          window1_present         = 1'b0,
    parameter bit          window1_space_type      = 1'b1,
    parameter int          window1_size_log2       = 8,
    parameter bit          window1_prefetchable    = 1'b0,
    parameter bit          hot_swap_present        = 1'b0
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address and data
    input  wire logic [AXI_AW-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    // axi4-lite write response
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [AXI_AW-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [31:0]       rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    // dma engine side
    input  wire pcibp_dma_evt_t    dma_evt,
    output wire pcibp_dma_t        dma_regs
);

    // ****************************************
    // build checks
    // ****************************************
    if (variant < VAR_TARGET || variant > VAR_TMASTER) begin : g_bad_variant
        $error("variant out of range");
    end
    if (window0_size_log2 < 8 || window0_size_log2 > 31) begin : g_bad_w0
        $error("window0 size out of range");
    end
    if (window1_present && window1_space_type &&
        (window1_size_log2 < 8 || window1_size_log2 > 31)) begin : g_bad_w1m
        $error("window1 memory size out of range");
    end
    if (window1_present && !window1_space_type &&
        (window1_size_log2 < 2 || window1_size_log2 > 8)) begin : g_bad_w1i
        $error("window1 io size out of range");
    end

    // ****************************************
    // derived build options
    // ****************************************
    localparam bit IS_MASTER = (variant == VAR_MASTER);
    localparam bit HAS_DMA   = (variant == VAR_TDMA);
    localparam bit DMA_CFG   = HAS_DMA && !dma_regs_in_io;
    localparam bit DMA_IO    = HAS_DMA && dma_regs_in_io;
    localparam bit W1_ON     = window1_present && !IS_MASTER;
    localparam bit HS_ON     = hot_swap_present && !IS_MASTER;
    localparam logic [31:0] RAM_MASK =
        ((32'h0000_0001 << window0_size_log2) - 32'h0000_0001) & ADDR_WMASK;
    localparam logic [31:0] CTL_MASK =
        wide_bus ? DMA_CTL_WMASK : (DMA_CTL_WMASK & ~(32'h1 << CTL_WIDE_BIT));
    localparam logic [31:0] ADDR_STEP = wide_bus ? 32'h0000_0008 : 32'h0000_0004;
    localparam logic [11:0] LEN_STEP  = wide_bus ? (DWORD_BYTES << 1) : DWORD_BYTES;

    // ****************************************
    // bus handshake
    // ****************************************
    logic        wr_do;
    logic        rd_do;
    logic [3:0]  w_space;
    logic [7:0]  w_ofs;
    logic        w_cfg;
    logic        w_io;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [15:0] cmd;
    logic [31:0] hs_reg;
    logic [31:0] pci_addr;
    logic [31:0] ram_addr;
    logic [31:0] dma_ctl;
    logic [31:0] bar0;
    logic [31:0] bar1;
    logic [31:0] bar2;

    assign wr_do   = awvalid && awready && wvalid && wready;
    assign rd_do   = arvalid && arready;
    assign w_space = awaddr[11:8];
    assign w_ofs   = {awaddr[7:2], 2'b00};
    assign w_cfg   = wr_do && (w_space == SPACE_CFG);
    assign w_io    = wr_do && (w_space == SPACE_IO) && DMA_IO && cmd[CMD_IO_EN_BIT];

    // address and data taken together, one cycle after both are offered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            awready <= awvalid && wvalid && !awready && !bvalid;
            wready  <= awvalid && wvalid && !awready && !bvalid;
        end
    end

    // write response; io space without a decoder answers slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid <= 1'b1;
            bresp  <= (w_space == SPACE_CFG || (w_space == SPACE_IO && DMA_IO)) ?
                      RESP_OKAY : RESP_SLV;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read address accepted only while no answer is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
        end else begin
            arready <= arvalid && !arready && !rvalid;
        end
    end

    // read answer registered from the decoded word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (rd_do) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_hit ? RESP_OKAY : RESP_SLV;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ****************************************
    // read decode
    // ****************************************
    // unimplemented header words read zero, as a pci host expects
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (araddr[11:8] == SPACE_CFG) begin
            unique case ({araddr[7:2], 2'b00})
                OFS_IDENT:   rd_word = {part_ident_const, maker_ident_const};
                OFS_CMDSTAT: begin
                    rd_word = {16'h0000, cmd};
                    rd_word[STAT_FAST_BIT]    = fast_clock_capable;
                    rd_word[STAT_CAPLIST_BIT] = HS_ON;
                end
                OFS_CLASS:   rd_word = {base_class_const, sub_class_const,
                                        prog_if_const, revision_ident_const};
                OFS_BAR0:    rd_word = bar0;
                OFS_BAR1:    rd_word = bar1;
                OFS_BAR2:    rd_word = bar2;
                OFS_BOARD:   rd_word = {board_ident_const, board_maker_ident_const};
                OFS_CAPPTR:  rd_word = HS_ON ? {24'h000000, CAP_PTR_HOTSWAP} : 32'h0;
                OFS_DMA_PCI: rd_word = DMA_CFG ? pci_addr : 32'h0;
                OFS_DMA_RAM: rd_word = DMA_CFG ? ram_addr : 32'h0;
                OFS_DMA_CTL: rd_word = DMA_CFG ? dma_ctl : 32'h0;
                OFS_HOTSWAP: rd_word = HS_ON ? hs_reg : 32'h0;
                default:     rd_word = 32'h0000_0000;
            endcase
        end else if (araddr[11:8] == SPACE_IO && DMA_IO) begin
            // io decode follows the command register's io enable
            if (cmd[CMD_IO_EN_BIT]) begin
                unique case ({araddr[7:2], 2'b00})
                    OFS_DMA_PCI: rd_word = pci_addr;
                    OFS_DMA_RAM: rd_word = ram_addr;
                    OFS_DMA_CTL: rd_word = dma_ctl;
                    default:     rd_word = 32'h0000_0000;
                endcase
            end
        end else begin
            rd_hit = 1'b0;
        end
    end

    // ****************************************
    // write helpers
    // ****************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [31:0] msk);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 32; i++) begin
            if (strb[i/8] && msk[i]) begin
                res[i] = nw[i];
            end
        end
        return res;
    endfunction

    logic dma_we_pci;
    logic dma_we_ram;
    logic dma_we_ctl;

    assign dma_we_pci = (w_cfg && DMA_CFG && w_ofs == OFS_DMA_PCI) ||
                        (w_io && w_ofs == OFS_DMA_PCI);
    assign dma_we_ram = (w_cfg && DMA_CFG && w_ofs == OFS_DMA_RAM) ||
                        (w_io && w_ofs == OFS_DMA_RAM);
    assign dma_we_ctl = (w_cfg && DMA_CFG && w_ofs == OFS_DMA_CTL) ||
                        (w_io && w_ofs == OFS_DMA_CTL);

    // ****************************************
    // command and hot-swap registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= CMD_RESET;
        end else if (w_cfg && w_ofs == OFS_CMDSTAT) begin
            cmd <= 16'(merge({16'h0000, cmd}, wdata, wstrb, {16'h0000, CMD_WMASK}));
        end
    end

    // capability id and next pointer are constant fields
    always_ff @(posedge aclk) begin
        if (!aresetn || !HS_ON) begin
            hs_reg <= {CAP_ID_HOTSWAP, CAP_NEXT_NONE, HS_RESET[15:0]};
        end else if (w_cfg && w_ofs == OFS_HOTSWAP) begin
            hs_reg <= merge(hs_reg, wdata, wstrb, HS_WMASK);
        end
    end

    // ****************************************
    // base address registers
    // ****************************************
    pcibp_bar #(
        .PRESENT   (!IS_MASTER),
        .IS_IO     (1'b0),
        .PREFETCH  (1'b0),
        .SIZE_LOG2 (window0_size_log2)
    ) u_bar0 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (w_cfg && w_ofs == OFS_BAR0),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .value   (bar0)
    );

    pcibp_bar #(
        .PRESENT   (W1_ON),
        .IS_IO     (!window1_space_type),
        .PREFETCH  (window1_prefetchable && window1_space_type),
        .SIZE_LOG2 (window1_size_log2)
    ) u_bar1 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (w_cfg && w_ofs == OFS_BAR1),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .value   (bar1)
    );

    // fixed 256-byte io window that carries the dma registers
    pcibp_bar #(
        .PRESENT   (DMA_IO),
        .IS_IO     (1'b1),
        .PREFETCH  (1'b0),
        .SIZE_LOG2 (IO_WIN_LOG2)
    ) u_bar2 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (w_cfg && w_ofs == OFS_BAR2),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .value   (bar2)
    );

    // ****************************************
    // dma registers
    // ****************************************
    // a beat and a software write in one cycle: software wins the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pci_addr <= DMA_RESET;
        end else if (dma_we_pci) begin
            pci_addr <= merge(pci_addr, wdata, wstrb, ADDR_WMASK);
        end else if (HAS_DMA && transfer_count_update_en && dma_evt.beat) begin
            pci_addr <= pci_addr + ADDR_STEP;
        end
    end

    // backend address wraps inside the window0-sized backend space
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ram_addr <= DMA_RESET;
        end else if (dma_we_ram) begin
            ram_addr <= merge(ram_addr, wdata, wstrb, RAM_MASK);
        end else if (HAS_DMA && transfer_count_update_en && dma_evt.beat) begin
            ram_addr <= (ram_addr + ADDR_STEP) & RAM_MASK;
        end
    end

    logic [31:0] ctl_w;
    logic [31:0] next_ctl;

    // done set by the engine wins over a clearing write
    always_comb begin
        ctl_w    = dma_we_ctl ? merge(dma_ctl, wdata, wstrb, CTL_MASK) : dma_ctl;
        next_ctl = ctl_w;
        if (dma_we_ctl && wstrb[0] && !wdata[CTL_DONE_BIT]) begin
            next_ctl[CTL_DONE_BIT] = 1'b0;
        end
        if (transfer_count_update_en && dma_evt.beat && !dma_we_ctl) begin
            next_ctl[CTL_LEN_MSB:CTL_LEN_LSB] =
                dma_ctl[CTL_LEN_MSB:CTL_LEN_LSB] - LEN_STEP;
        end
        if (dma_evt.finish || dma_evt.abort) begin
            next_ctl[CTL_DONE_BIT] = 1'b1;
            next_ctl[CTL_REQ_BIT]  = 1'b0;
        end
        if (dma_evt.abort) begin
            next_ctl[1:0] = dma_evt.err_code;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !HAS_DMA) begin
            dma_ctl <= DMA_RESET;
        end else begin
            dma_ctl <= next_ctl;
        end
    end

    assign dma_regs = '{pci_addr: pci_addr, ram_addr: ram_addr, ctrl: dma_ctl};

    // protection attributes carry no meaning for this bank
    logic unused_prot;
    assign unused_prot = ^{awprot, arprot};

endmodule
`default_nettype wire

// ### pcibp_regs_checker.sv
// assertions on the register bank's bus handshakes and dma counting
`timescale 1ns/1ns
`default_nettype none
module pcibp_regs_checker import pcibp_pkg::*; (
    // clock, reset and handshakes
    input wire logic           aclk, aresetn, awvalid, wvalid, awready, wready,
    input wire logic           bvalid, bready, arvalid, arready, rvalid, rready,
    // answer payloads
    input wire logic [1:0]     bresp,
    input wire logic [31:0]    rdata,
    // dma side
    input wire pcibp_dma_evt_t dma_evt,
    input wire pcibp_dma_t     dma_regs
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a full offer with nothing pending must be taken next cycle
    sequence s_write_offer; awvalid && wvalid && !awready && !bvalid; endsequence
    sequence s_read_offer; arvalid && !arready && !rvalid; endsequence
    a_write_take: assert property (s_write_offer |=> awready && wready)
        else $error("write offer not taken");
    a_write_resp: assert property (awready |=> !awready && bvalid)
        else $error("write response late");
    a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_read_take: assert property (s_read_offer |=> arready)
        else $error("read offer not taken");
    a_read_resp: assert property (arready |=> !arready && rvalid)
        else $error("read data late");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    // counts assume the 32-bit build; a same-cycle write wins
    a_pci_count: assert property (dma_evt.beat && !awready |=>
        dma_regs.pci_addr == $past(dma_regs.pci_addr) + 32'h4) else $error("pci addr step");
    a_ram_wrap: assert property (dma_evt.beat && !awready |=> dma_regs.ram_addr[31:24] == 8'h0
        && dma_regs.ram_addr[23:0] == $past(dma_regs.ram_addr[23:0]) + 24'h4)
        else $error("ram addr step");
    a_len_count: assert property (dma_evt.beat && !awready |=>
        dma_regs.ctrl[27:16] == $past(dma_regs.ctrl[27:16]) - 12'h4) else $error("length step");
    a_finish_done: assert property (dma_evt.finish |=> dma_regs.ctrl[2] && !dma_regs.ctrl[4])
        else $error("done not flagged");
endmodule
bind pcibp_regs pcibp_regs_checker i_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .wvalid(wvalid), .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .bresp(bresp),
    .rdata(rdata), .dma_evt(dma_evt), .dma_regs(dma_regs));
`default_nettype wire

// ### pcibp_dma_partner.sv
// transfer engine model: pulses beats, then a finish
`timescale 1ns/1ns
`default_nettype none
module pcibp_dma_partner import pcibp_pkg::*; (
    // clock and reset
    input wire logic      aclk, aresetn,
    // command from the bench
    input wire logic      go, slow,
    input wire logic [3:0] beats,
    // event pulses and status
    output var pcibp_dma_evt_t evt,
    output var logic      busy
);
    logic [3:0] left;
    logic       gap;
    // slow mode idles a cycle between beats, as a stalled bus would
    always_ff @(posedge aclk) begin
        evt <= '0;
        if (!aresetn) begin
            busy <= 1'b0;
            left <= 4'h0;
            gap  <= 1'b0;
        end else if (go) begin
            busy <= 1'b1;
            left <= beats;
            gap  <= 1'b0;
        end else if (busy) begin
            gap <= slow & ~gap;
            if (left != 4'h0 && !gap) begin
                evt.beat <= 1'b1;
                left     <= left - 4'h1;
            end else if (left == 4'h0) begin
                evt.finish <= 1'b1;
                busy       <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### pcibp_regs_test.sv
// self-checking bench for the build-parameter register bank
`timescale 1ns/1ns
`default_nettype none
module pcibp_regs_test import pcibp_pkg::*;;
    logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, slow = 1'b1, busy;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [1:0]  bresp, rresp;
    logic [3:0]  beats = 4'h2, wstrb = 4'hf;
    logic [2:0]  prot = 3'h0;
    pcibp_dma_evt_t evt;
    pcibp_dma_t     dregs;
    int err_count = 0, compares = 0;
    always #25 aclk = ~aclk;
    // identity values are arbitrary
    localparam logic [95:0] IDS = 96'h0a0b_0c0d_05_0f_20_01_1234_5678;
    pcibp_regs #(.part_ident_const(IDS[95:80]), .maker_ident_const(IDS[79:64]),
        .revision_ident_const(IDS[63:56]), .base_class_const(IDS[55:48]),
        .sub_class_const(IDS[47:40]), .prog_if_const(IDS[39:32]),
        .board_ident_const(IDS[31:16]), .board_maker_ident_const(IDS[15:0]),
        .fast_clock_capable(1'b1), .hot_swap_present(1'b1), .window1_present(1'b1),
        .window1_space_type(1'b0), .window1_size_log2(4)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(prot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(prot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .dma_evt(evt),
        .dma_regs(dregs));
    pcibp_dma_partner i_eng (.aclk(aclk), .aresetn(aresetn), .go(go), .slow(slow),
        .beats(beats), .evt(evt), .busy(busy));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // one write; bready up until the answer
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0; wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge aclk);
    endtask
    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        chk(n, e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge aclk);
    endtask
    task automatic t_ident;
        wr(12'h000, 32'hffff_ffff, RESP_OKAY);
        rd("ident", 12'h000, 32'h0a0b_0c0d, RESP_OKAY);
        rd("class", 12'h008, 32'h0f20_0105, RESP_OKAY);
        rd("board", 12'h02c, 32'h1234_5678, RESP_OKAY);
        $display("done ident");
    endtask
    task automatic t_status;
        rd("status", 12'h004, 32'h0030_0000, RESP_OKAY);
        rd("capptr", 12'h034, 32'h0000_0080, RESP_OKAY);
        wr(12'h080, 32'hffff_ffff, RESP_OKAY);
        rd("hotswap", 12'h080, 32'h0600_ca00, RESP_OKAY);
        $display("done status");
    endtask
    task automatic t_bars;
        wr(12'h010, 32'hffff_ffff, RESP_OKAY);
        rd("bar0", 12'h010, 32'hff00_0000, RESP_OKAY);
        wstrb <= 4'h1;
        wr(12'h014, 32'hffff_ffff, RESP_OKAY);
        wstrb <= 4'hf;
        rd("bar1", 12'h014, 32'h0000_00f1, RESP_OKAY);
        $display("done bars");
    endtask
    // two stalled beats wrap ram at 16 Mbyte
    task automatic t_dma;
        wr(12'h040, 32'h1000_0000, RESP_OKAY);
        wr(12'h044, 32'h00ff_fffc, RESP_OKAY);
        wr(12'h048, 32'h0010_0010, RESP_OKAY);
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        do @(posedge aclk); while (busy !== 1'b0);
        rd("pci", 12'h040, 32'h1000_0008, RESP_OKAY);
        rd("ram", 12'h044, 32'h0000_0004, RESP_OKAY);
        rd("ctrl", 12'h048, 32'h0008_0004, RESP_OKAY);
        chk("port", 32'h1000_0008, dregs.pci_addr);
        $display("done dma");
    endtask
    // dma config-mapped: io window refuses
    task automatic t_refuse;
        rd("io dma", 12'h140, 32'h0000_0000, RESP_SLV);
        rd("space2", 12'h200, 32'h0000_0000, RESP_SLV);
        wr(12'h240, 32'h0000_0001, RESP_SLV);
        $display("done refuse");
    endtask
    task automatic give_verdict;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_ident;
        t_status;
        t_bars;
        t_dma;
        t_refuse;
        give_verdict;
    end
    // tests need well under 200 cycles
    initial begin
        repeat (3000) @(posedge aclk);
        err_count++;
        give_verdict;
    end
endmodule
`default_nettype wire
